/* File: core/csct_cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each phase lasts prescale times multiplier plus one card clocks.
// - Phases count in card clocks of two host clocks each.
// - Address, attribute, enables and write data stand the setup count before strobe, except the I/O high-byte enable, which waits for the indication.
// - Command strobe stays low at least the command count.
// - Address and write data hold the recovery count after strobe rises.
// - Timer set zero resets to 01h, 05h and 00h.
// - Each set owns setup, command and recovery registers at 3Ah-3Fh.
// - Strobe stays low two card clocks after wait is released.
// - Late word indication is ignored; high-byte enable stays inactive.
// - High-byte enable falls no sooner than one card clock after indication.
// - On 8-bit systems write data leads strobe release by two card clocks.
// - Timing register: prescale code in bits 7-6, multiplier in 5-0.
module csct_cycle_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Card side
    output csct_pkg::csct_card_t card,
    input wire logic card_wait_n,
    input wire logic io_word_width_indication_n,
    input wire logic [15:0] card_rdata
);
    import csct_pkg::*;

    typedef struct packed {
        csct_phase_t phase;
        logic tick;
        logic [18:0] cnt;
        logic [18:0] elapsed;
        logic [18:0] hold;
        logic waited;
        logic is16_seen;
        logic [7:0] ctrl;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic late_is16;
        logic done;
        logic rd_pend;
        csct_card_t card;
    } csct_state_t;

    csct_state_t st;
    csct_state_t next_st;
    logic [7:0] regs [0:5];
    logic [7:0] bank_rd;
    logic bank_wr;
    logic [2:0] bank_wsel;
    logic [2:0] bank_rsel;
    logic [7:0] word_idx;
    logic access;
    logic [18:0] len_s;
    logic [18:0] len_c;
    logic [18:0] len_r;
    logic is_bank;

    // Word index from byte address; registers sit one word each
    assign word_idx = paddr[9:2];
    assign is_bank = (word_idx >= CSCT_IDX_SETUP0) && (word_idx <= CSCT_IDX_REC1);
    assign access = psel && penable;
    assign bank_wr = access && pwrite && is_bank;
    assign bank_wsel = 3'(word_idx - CSCT_IDX_SETUP0);
    assign bank_rsel = is_bank ? 3'(word_idx - CSCT_IDX_SETUP0) : 3'h7;

    csct_timer_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(bank_wr),
        .wr_sel(bank_wsel),
        .wr_data(pwdata[7:0]),
        .rd_sel(bank_rsel),
        .rd_data(bank_rd),
        .regs_flat(regs)
    );

    // Lengths of the selected set
    always_comb begin
        if (st.ctrl[CSCT_CTRL_SET]) begin
            len_s = csct_len(regs[3]);
            len_c = csct_len(regs[4]);
            len_r = csct_len(regs[5]);
        end else begin
            len_s = csct_len(regs[0]);
            len_c = csct_len(regs[1]);
            len_r = csct_len(regs[2]);
        end
    end

    // Bank reads need one cycle to reach the read register
    assign pready = !(is_bank && !pwrite) || st.rd_pend;
    assign pslverr = 1'b0;

    // Read mux
    always_comb begin
        if (is_bank) begin
            prdata = {24'h000000, bank_rd};
        end else if (word_idx == CSCT_IDX_CTRL) begin
            prdata = {16'h0000, st.addr, st.ctrl};
        end else if (word_idx == CSCT_IDX_STAT) begin
            prdata = {27'h0000000, st.late_is16, st.done, st.waited,
                      st.phase};
        end else if (word_idx == CSCT_IDX_RDATA) begin
            prdata = {16'h0000, st.rdata};
        end else begin
            prdata = CSCT_BAD_READ;
        end
    end

    // Sequencer: one state step per card clock
    always_comb begin
        next_st = st;
        next_st.rd_pend = access && !pwrite && is_bank && !st.rd_pend;
        next_st.tick = !st.tick;
        if (access && pwrite && word_idx == CSCT_IDX_STAT) begin
            next_st.done = 1'b0;
            next_st.late_is16 = 1'b0;
        end
        if (access && pwrite && word_idx == CSCT_IDX_CTRL && st.phase == CSCT_IDLE) begin
            next_st.ctrl = pwdata[7:0];
            next_st.addr = pwdata[CSCT_CTRL_ADDR_LSB +: 8];
            next_st.wdata = pwdata[CSCT_CTRL_WDATA_LSB +: 16];
        end
        if (st.phase == CSCT_IDLE && st.ctrl[CSCT_CTRL_GO]) begin
            // Present address, space, enables, data before strobe
            next_st.ctrl[CSCT_CTRL_GO] = 1'b0;
            next_st.phase = CSCT_SETUP;
            next_st.cnt = len_s;
            next_st.tick = 1'b0;
            next_st.elapsed = '0;
            next_st.waited = 1'b0;
            next_st.is16_seen = 1'b0;
            next_st.card.addr = st.addr;
            next_st.card.wdata = st.wdata;
            next_st.card.wdata_oe = st.ctrl[CSCT_CTRL_WR];
            next_st.card.attr_n = !st.ctrl[CSCT_CTRL_ATTR];
            next_st.card.low_byte_enable_n = 1'b0;
            next_st.card.high_byte_card_enable_n =
                st.ctrl[CSCT_CTRL_IO] || !st.ctrl[CSCT_CTRL_WORD];
        end else if (st.phase != CSCT_IDLE && st.tick) begin
            next_st.elapsed = st.elapsed + 19'h00001;
            // Word indication window and delayed high-byte enable
            if (st.ctrl[CSCT_CTRL_IO] && st.ctrl[CSCT_CTRL_WORD]) begin
                if (!io_word_width_indication_n && st.elapsed < CSCT_IS16_LIMIT) begin
                    next_st.is16_seen = 1'b1;
                end else if (!st.is16_seen && st.elapsed == CSCT_IS16_LIMIT) begin
                    next_st.late_is16 = 1'b1;
                end
                if (st.is16_seen && st.phase != CSCT_REC) begin
                    next_st.card.high_byte_card_enable_n = 1'b0;
                end
            end
            if (st.cnt > 19'h00001) begin
                next_st.cnt = st.cnt - 19'h00001;
            end
            case (st.phase)
                CSCT_SETUP: begin
                    if (st.cnt == 19'h00001) begin
                        next_st.phase = CSCT_CMD;
                        next_st.cnt = len_c;
                        next_st.hold = '0;
                        next_st.card.mem_read_strobe_n =
                            st.ctrl[CSCT_CTRL_IO] || st.ctrl[CSCT_CTRL_WR];
                        next_st.card.mem_write_strobe_n =
                            st.ctrl[CSCT_CTRL_IO] || !st.ctrl[CSCT_CTRL_WR];
                        next_st.card.io_read_strobe_n =
                            !st.ctrl[CSCT_CTRL_IO] || st.ctrl[CSCT_CTRL_WR];
                        next_st.card.io_write_strobe_n =
                            !st.ctrl[CSCT_CTRL_IO] || !st.ctrl[CSCT_CTRL_WR];
                    end
                end
                CSCT_CMD: begin
                    // Freeze count while card holds wait
                    if (!card_wait_n) begin
                        next_st.cnt = st.cnt;
                        next_st.waited = 1'b1;
                        next_st.hold = '0;
                    end else if (st.hold < CSCT_WAIT_HOLD) begin
                        next_st.hold = st.hold + 19'h00001;
                    end
                    // End after count and two clocks past wait release
                    if (card_wait_n && st.cnt == 19'h00001 &&
                            (!st.waited || st.hold >= CSCT_WAIT_HOLD)) begin
                        next_st.phase = CSCT_REC;
                        next_st.cnt = len_r;
                        next_st.rdata = card_rdata;
                        next_st.card.mem_read_strobe_n = 1'b1;
                        next_st.card.mem_write_strobe_n = 1'b1;
                        next_st.card.io_read_strobe_n = 1'b1;
                        next_st.card.io_write_strobe_n = 1'b1;
                        next_st.card.high_byte_card_enable_n = 1'b1;
                    end
                end
                CSCT_REC: begin
                    // Address and data held through recovery
                    if (st.cnt == 19'h00001) begin
                        next_st.phase = CSCT_IDLE;
                        next_st.done = 1'b1;
                        next_st.card.wdata_oe = 1'b0;
                        next_st.card.low_byte_enable_n = 1'b1;
                        next_st.card.attr_n = 1'b1;
                    end
                end
                default: next_st.phase = CSCT_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.card.attr_n <= 1'b1;
            st.card.low_byte_enable_n <= 1'b1;
            st.card.high_byte_card_enable_n <= 1'b1;
            st.card.mem_read_strobe_n <= 1'b1;
            st.card.mem_write_strobe_n <= 1'b1;
            st.card.io_read_strobe_n <= 1'b1;
            st.card.io_write_strobe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign card = st.card;

    // Helper: host clocks with a strobe low
    logic [19:0] strobe_cycles;
    logic strobe_low;
    assign strobe_low = !(st.card.mem_read_strobe_n && st.card.mem_write_strobe_n &&
                          st.card.io_read_strobe_n && st.card.io_write_strobe_n);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_cycles <= '0;
        end else begin
            strobe_cycles <= strobe_low ? strobe_cycles + 20'h00001 : '0;
        end
    end

    // Helper: host clocks with enables out and no strobe yet
    logic [19:0] setup_cycles;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_cycles <= '0;
        end else begin
            setup_cycles <= (st.phase == CSCT_SETUP && !st.card.low_byte_enable_n && !strobe_low)
                ? setup_cycles + 20'h00001 : '0;
        end
    end

    property p_cmd_min;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.phase == CSCT_REC) |-> $past(strobe_cycles) + 20'h00001 >=
            20'(2 * csct_len(st.ctrl[CSCT_CTRL_SET] ? regs[4] : regs[1]));
    endproperty
    a_cmd_min: assert property (p_cmd_min) else $error("command too short");

    property p_setup_enters_cmd;
        @(posedge pclk) disable iff (!presetn)
        $rose(strobe_low) |-> setup_cycles >=
            20'(2 * csct_len(st.ctrl[CSCT_CTRL_SET] ? regs[3] : regs[0]));
    endproperty
    a_setup_enters_cmd: assert property (p_setup_enters_cmd) else $error("setup too short");

    property p_addr_stable;
        @(posedge pclk) disable iff (!presetn)
        st.phase == CSCT_REC |-> $stable(st.card.addr) && $stable(st.card.wdata);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");

    property p_wait_hold;
        @(posedge pclk) disable iff (!presetn)
        $rose(card_wait_n) && st.phase == CSCT_CMD |-> strobe_low [*4];
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("strobe rose too early");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        st.phase == CSCT_CMD && !card_wait_n && st.tick |=> $stable(st.cnt);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter ran in wait");

    property p_order;
        @(posedge pclk) disable iff (!presetn)
        st.phase != $past(st.phase) |->
            ($past(st.phase) == CSCT_IDLE && st.phase == CSCT_SETUP) ||
            ($past(st.phase) == CSCT_SETUP && st.phase == CSCT_CMD) ||
            ($past(st.phase) == CSCT_CMD && st.phase == CSCT_REC) ||
            ($past(st.phase) == CSCT_REC && st.phase == CSCT_IDLE);
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");

    property p_tick;
        @(posedge pclk) disable iff (!presetn)
        st.phase != $past(st.phase) && st.phase != CSCT_SETUP |-> $past(st.tick);
    endproperty
    a_tick: assert property (p_tick) else $error("phase off card clock");

    property p_late_is16;
        @(posedge pclk) disable iff (!presetn)
        st.late_is16 && st.phase != CSCT_IDLE |-> st.card.high_byte_card_enable_n;
    endproperty
    a_late_is16: assert property (p_late_is16) else $error("high byte after late");

    property p_word_gate;
        @(posedge pclk) disable iff (!presetn)
        st.phase != CSCT_IDLE && st.ctrl[CSCT_CTRL_IO] && !st.is16_seen |->
            st.card.high_byte_card_enable_n;
    endproperty
    a_word_gate: assert property (p_word_gate) else $error("high byte without width");

    property p_ce2_delay;
        @(posedge pclk) disable iff (!presetn)
        $fell(st.card.high_byte_card_enable_n) && st.ctrl[CSCT_CTRL_IO] |->
            $past(st.is16_seen);
    endproperty
    a_ce2_delay: assert property (p_ce2_delay) else $error("high byte too soon");

    property p_wdata_lead;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.phase == CSCT_REC) && st.ctrl[CSCT_CTRL_SYS8] && st.card.wdata_oe
            |-> $past(st.card.wdata_oe, 4);
    endproperty
    a_wdata_lead: assert property (p_wdata_lead) else $error("write data late");

    property p_defaults;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> csct_len(regs[1]) == 19'h00006;
    endproperty
    a_defaults: assert property (p_defaults) else $error("bad reset timing");
endmodule : csct_cycle_timer
`default_nettype wire

/* File: core/csct_pkg.sv */
package csct_pkg;
    // Register offsets (byte addresses = index * 4)
    localparam logic [7:0] CSCT_IDX_SETUP0 = 8'h3a;
    localparam logic [7:0] CSCT_IDX_CMD0 = 8'h3b;
    localparam logic [7:0] CSCT_IDX_REC0 = 8'h3c;
    localparam logic [7:0] CSCT_IDX_SETUP1 = 8'h3d;
    localparam logic [7:0] CSCT_IDX_CMD1 = 8'h3e;
    localparam logic [7:0] CSCT_IDX_REC1 = 8'h3f;
    localparam logic [7:0] CSCT_IDX_CTRL = 8'h40;
    localparam logic [7:0] CSCT_IDX_STAT = 8'h41;
    localparam logic [7:0] CSCT_IDX_RDATA = 8'h42;
    // Reset values of timer sets zero and one
    localparam logic [7:0] CSCT_RST_SETUP0 = 8'h01;
    localparam logic [7:0] CSCT_RST_CMD0 = 8'h05;
    localparam logic [7:0] CSCT_RST_REC0 = 8'h00;
    localparam logic [7:0] CSCT_RST_SET1 = 8'h00;
    // Timing register fields
    localparam int CSCT_PRES_MSB = 7;
    localparam int CSCT_PRES_LSB = 6;
    localparam int CSCT_VAL_MSB = 5;
    // Prescale factors for codes 00..11
    localparam logic [12:0] CSCT_PRES0 = 13'h0001;
    localparam logic [12:0] CSCT_PRES1 = 13'h0010;
    localparam logic [12:0] CSCT_PRES2 = 13'h0100;
    localparam logic [12:0] CSCT_PRES3 = 13'h1000;
    // Card clock is two host clocks; wait hold and late limits in card clocks
    localparam logic [1:0] CSCT_TCP_HALF = 2'h1;
    localparam logic [18:0] CSCT_WAIT_HOLD = 19'h00002;
    localparam logic [18:0] CSCT_IS16_LIMIT = 19'h00003;
    localparam logic [18:0] CSCT_WDATA_LEAD = 19'h00002;
    // Control register bits
    localparam int CSCT_CTRL_GO = 0;
    localparam int CSCT_CTRL_WR = 1;
    localparam int CSCT_CTRL_IO = 2;
    localparam int CSCT_CTRL_WORD = 3;
    localparam int CSCT_CTRL_SET = 4;
    localparam int CSCT_CTRL_ATTR = 5;
    localparam int CSCT_CTRL_SYS8 = 6;
    localparam int CSCT_CTRL_ADDR_LSB = 8;
    localparam int CSCT_CTRL_WDATA_LSB = 16;
    localparam logic [31:0] CSCT_BAD_READ = 32'h00000000;

    // Access phases, Gray along idle-setup-command-recovery
    typedef enum logic [1:0] {
        CSCT_IDLE = 2'b00,
        CSCT_SETUP = 2'b01,
        CSCT_CMD = 2'b11,
        CSCT_REC = 2'b10
    } csct_phase_t;

    // Card-side outputs travel together
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wdata_oe;
        logic attr_n;
        logic low_byte_enable_n;
        logic high_byte_card_enable_n;
        logic mem_read_strobe_n;
        logic mem_write_strobe_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
    } csct_card_t;

    // Decoded phase length: prescale * multiplier + 1 card clocks
    function automatic logic [18:0] csct_len(input logic [7:0] r);
        logic [12:0] p;
        p = CSCT_PRES0;
        case (r[CSCT_PRES_MSB:CSCT_PRES_LSB])
            2'b01: p = CSCT_PRES1;
            2'b10: p = CSCT_PRES2;
            2'b11: p = CSCT_PRES3;
            default: p = CSCT_PRES0;
        endcase
        return 19'(p) * 19'(r[CSCT_VAL_MSB:0]) + 19'h00001;
    endfunction : csct_len
endpackage : csct_pkg

/* File: core/csct_timer_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Two timer sets of three registers; read data from a register
module csct_timer_bank (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write port
    input wire logic wr_en,
    input wire logic [2:0] wr_sel,
    input wire logic [7:0] wr_data,
    // Read port, registered
    input wire logic [2:0] rd_sel,
    output logic [7:0] rd_data,
    // Live view for the sequencer
    output logic [7:0] regs_flat [0:5]
);
    import csct_pkg::*;

    typedef struct packed {
        logic [5:0][7:0] r;
        logic [7:0] rd;
    } csct_bank_t;

    csct_bank_t st;
    csct_bank_t next_st;

    // Writes and registered read
    always_comb begin
        next_st = st;
        if (wr_en && wr_sel < 3'h6) begin
            next_st.r[wr_sel] = wr_data;
        end
        next_st.rd = (rd_sel < 3'h6) ? st.r[rd_sel] : 8'h00;
    end

    // Set zero comes up at its defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.r[0] <= CSCT_RST_SETUP0;
            st.r[1] <= CSCT_RST_CMD0;
            st.r[2] <= CSCT_RST_REC0;
            st.r[3] <= CSCT_RST_SET1;
            st.r[4] <= CSCT_RST_SET1;
            st.r[5] <= CSCT_RST_SET1;
            st.rd <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            regs_flat[i] = st.r[i];
        end
    end
endmodule : csct_timer_bank
`default_nettype wire

/* File: tb/card_socket_cycle_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("MISMATCH t=%0t %s", $time, msg); end end
module card_socket_cycle_timer_tb;
    import csct_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    csct_card_t card;
    logic card_wait_n, is16_n, word_ok, mon_on, seen_cmd, hb_seen, hb_early, attr_seen;
    logic [15:0] card_rdata, rd_value, exp_wd;
    logic [7:0] wait_len, exp_addr;
    logic [7:0] tregs [0:5];
    logic [7:0] modes [0:6];
    logic [3:0] smask;
    int bad_count, samples_checked, s_cnt, c_cnt, r_cnt, hold_cnt, ind_cnt, stab_bad;
    logic wr_mode;
    wire logic en_on = !card.low_byte_enable_n || !card.high_byte_card_enable_n;
    wire logic strobe_on = !(card.mem_read_strobe_n && card.mem_write_strobe_n
        && card.io_read_strobe_n && card.io_write_strobe_n);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    csct_cycle_timer csct_cycle_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .card(card), .card_wait_n(card_wait_n),
        .io_word_width_indication_n(is16_n), .card_rdata(card_rdata));
    csct_card_model csct_card_model_inst (.pclk(pclk), .presetn(presetn), .card(card),
        .rd_value(rd_value), .wait_len(wait_len), .word_ok(word_ok),
        .card_wait_n(card_wait_n), .io_word_width_indication_n(is16_n),
        .card_rdata(card_rdata));

    // Phase lengths in host clocks, independent of the package helper
    function automatic int exp_len(input logic [7:0] r);
        int p;
        p = (r[7:6] == 2'b00) ? 1 : (r[7:6] == 2'b01) ? 16 : (r[7:6] == 2'b10) ? 256 : 4096;
        return 2 * (p * int'(r[5:0]) + 1);
    endfunction : exp_len

    // Socket watcher: phase counts, stability, strobes used
    always @(posedge pclk) begin
        if (mon_on) begin
            if (en_on && !strobe_on && !seen_cmd) s_cnt++;
            if (en_on && !strobe_on && seen_cmd) r_cnt++;
            if (strobe_on) begin
                c_cnt++;
                seen_cmd = 1'b1;
                hold_cnt = card_wait_n ? hold_cnt + 1 : 0;
                smask |= ~{card.mem_read_strobe_n, card.mem_write_strobe_n,
                    card.io_read_strobe_n, card.io_write_strobe_n};
            end
            if (en_on && (card.addr !== exp_addr || card.wdata_oe !== wr_mode
                || (wr_mode && card.wdata !== exp_wd))) stab_bad++;
            if (!card.attr_n) attr_seen = 1'b1;
            if (!is16_n) ind_cnt++;
            if (!card.high_byte_card_enable_n) begin
                hb_seen = 1'b1;
                if (ind_cnt < 2) hb_early = 1'b1;
            end
        end
    end

    // One APB transfer; result left in q
    task automatic apb_xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        `CHK(n < 50, 1'b1, "apb hang")
        `CHK(pslverr, 1'b0, "slave error")
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb_xfer

    // Fresh short timings for one set, no prescale
    task automatic prog(input int set);
        for (int k = 0; k < 3; k++) begin
            tregs[set * 3 + k] = 8'($urandom_range(k == 1 ? 2 : 0, k == 1 ? 6 : 5));
            apb_xfer(1'b1, CSCT_IDX_SETUP0 + 8'(set * 3 + k), {24'h0, tregs[set * 3 + k]});
        end
    endtask : prog

    task automatic run_access(input logic [7:0] ctl, input logic [7:0] wl, input logic wok);
        int n;
        int b;
        b = ctl[4] ? 3 : 0;
        exp_addr = 8'($urandom);
        exp_wd = 16'($urandom);
        rd_value <= 16'($urandom);
        wait_len <= wl;
        word_ok <= wok;
        wr_mode = ctl[1];
        {s_cnt, c_cnt, r_cnt, hold_cnt, ind_cnt, stab_bad} = '0;
        {seen_cmd, hb_seen, hb_early, attr_seen, smask} = '0;
        mon_on = 1'b1;
        apb_xfer(1'b1, CSCT_IDX_CTRL, {exp_wd, exp_addr, ctl});
        n = 0;
        while (!(seen_cmd && !en_on) && n < 30000) begin
            @(negedge pclk);
            n++;
        end
        mon_on = 1'b0;
        `CHK(n < 30000, 1'b1, "access hang")
        `CHK(s_cnt, exp_len(tregs[b]), "setup length")
        if (wl == 8'h00) `CHK(c_cnt, exp_len(tregs[b + 1]), "command length")
        else begin
            `CHK(c_cnt >= exp_len(tregs[b + 1]) + int'(wl), 1'b1, "stretch short")
            `CHK(hold_cnt >= 4, 1'b1, "hold after wait")
        end
        `CHK(r_cnt, exp_len(tregs[b + 2]), "recovery length")
        `CHK(stab_bad, 0, "addr or data moved")
        `CHK(smask, ctl[2] ? (ctl[1] ? 4'h1 : 4'h2) : (ctl[1] ? 4'h4 : 4'h8), "strobe")
        `CHK(attr_seen, ctl[5], "attribute select")
        if (ctl[3]) begin
            `CHK(hb_seen, wok, "high byte enable")
            `CHK(hb_early, 1'b0, "high byte early")
        end
        if (!ctl[1]) begin
            apb_xfer(1'b0, CSCT_IDX_RDATA, 32'h0);
            `CHK(q[15:0], rd_value, "read data")
        end
        apb_xfer(1'b0, CSCT_IDX_STAT, 32'h0);
        `CHK(q[3], 1'b1, "done flag")
        `CHK(q[2], wl != 8'h00, "waited flag")
        if (ctl[3]) `CHK(q[4], !wok, "late indication")
        apb_xfer(1'b1, CSCT_IDX_STAT, 32'h0);
    endtask : run_access

    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the longest expected run
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, word_ok, mon_on} = '0;
        {wait_len, rd_value, bad_count, samples_checked} = '0;
        modes = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h21, 8'h0d, 8'h43};
        void'($urandom(32'hc0fe6082));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then random write and read-back
        tregs = '{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 6; k++) begin
            apb_xfer(1'b0, CSCT_IDX_SETUP0 + 8'(k), 32'h0);
            `CHK(q[7:0], tregs[k], "reset value")
            tregs[k] = 8'($urandom);
            apb_xfer(1'b1, CSCT_IDX_SETUP0 + 8'(k), {24'h0, tregs[k]});
            apb_xfer(1'b0, CSCT_IDX_SETUP0 + 8'(k), 32'h0);
            `CHK(q[7:0], tregs[k], "read-back")
        end
        apb_xfer(1'b1, 8'h80, 32'hffffffff);
        apb_xfer(1'b0, 8'h80, 32'h0);
        `CHK(q, CSCT_BAD_READ, "unmapped read")
        // Prescale code 01: setup of 17 card clocks
        tregs[0:2] = '{8'h41, 8'h03, 8'h00};
        for (int k = 0; k < 3; k++) apb_xfer(1'b1, CSCT_IDX_SETUP0 + 8'(k), {24'h0, tregs[k]});
        run_access(8'h01, 8'h00, 1'b0);
        // Every access kind, plain then stretched, random set
        for (int it = 0; it < 2; it++) begin
            for (int m = 0; m < 7; m++) begin
                prog(0);
                prog(1);
                run_access(modes[m] | {3'b000, 1'($urandom), 4'h0},
                    it ? 8'($urandom_range(3, 9)) : 8'h00, 1'($urandom));
            end
        end
        wrap_up();
    end
endmodule : card_socket_cycle_timer_tb
`default_nettype wire

/* File: tb/csct_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural card in the socket: wait stretching, read data, word indication
module csct_card_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Socket signals from the adapter
    input wire csct_pkg::csct_card_t card,
    // Knobs from the bench
    input wire logic [15:0] rd_value,
    input wire logic [7:0] wait_len,
    input wire logic word_ok,
    // Card answers
    output logic card_wait_n,
    output logic io_word_width_indication_n,
    output logic [15:0] card_rdata
);
    import csct_pkg::*;
    logic strobe_on;
    logic waited;
    logic [7:0] wcnt;
    assign strobe_on = !(card.mem_read_strobe_n && card.mem_write_strobe_n
        && card.io_read_strobe_n && card.io_write_strobe_n);
    // Wait goes low on the first command edge; data toggles when not driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_wait_n <= 1'b1;
            waited <= 1'b0;
            wcnt <= 8'h00;
            card_rdata <= 16'h5a5a;
            io_word_width_indication_n <= 1'b1;
        end else begin
            if (!strobe_on) begin
                waited <= 1'b0;
                card_wait_n <= 1'b1;
                wcnt <= 8'h00;
            end else if (!waited && wait_len != 8'h00) begin
                card_wait_n <= 1'b0;
                wcnt <= wait_len;
                waited <= 1'b1;
            end else if (wcnt > 8'h01) begin
                wcnt <= wcnt - 8'h01;
            end else begin
                wcnt <= 8'h00;
                card_wait_n <= 1'b1;
            end
            // Valid data together with the wait release, held to strobe end
            if (strobe_on && wcnt <= 8'h01 && (waited || wait_len == 8'h00)) begin
                card_rdata <= rd_value;
            end else begin
                card_rdata <= ~card_rdata;
            end
            // Word indication follows the low-byte enable one clock late
            io_word_width_indication_n <= !(word_ok && !card.low_byte_enable_n);
        end
    end
endmodule : csct_card_model
`default_nettype wire
